// [hw/iogc_defs.vh]
`ifndef IOGC_DEFS_VH
`define IOGC_DEFS_VH

// ------------------------------------------------------------
// Register bus
// ------------------------------------------------------------
`define IOGC_ADDR_W 8
`define IOGC_DATA_W 32
`define IOGC_ADDR_INV 8'h00
`define IOGC_ADDR_CFG 8'h04
`define IOGC_ADDR_STAT 8'h08

// ------------------------------------------------------------
// Control signal lanes (inversion mask bit positions)
// ------------------------------------------------------------
`define IOGC_NCTRL 4
`define IOGC_CTL_CLKEN 0
`define IOGC_CTL_LOCAL 1
`define IOGC_CTL_EDGE 2
`define IOGC_CTL_TRIST 3

// ------------------------------------------------------------
// Configuration register fields
// ------------------------------------------------------------
`define IOGC_CFG_GSREN 0
`define IOGC_CFG_HSSEL 1
`define IOGC_CFG_INDLY_LO 2
`define IOGC_CFG_INDLY_HI 3
`define IOGC_CFG_OUTDLY_LO 4
`define IOGC_CFG_OUTDLY_HI 5
`define IOGC_CFG_CHAINSEL 6
`define IOGC_CFG_UPDSEL 7
`define IOGC_CFG_RSTSEL 8
`define IOGC_CFG_RATIO_LO 9
`define IOGC_CFG_RATIO_HI 10
`define IOGC_CFG_POS_LO 11
`define IOGC_CFG_POS_HI 12
`define IOGC_CFG_TRIST 13
`define IOGC_CFG_W 14

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define IOGC_INV_RST 4'h0
`define IOGC_CFG_RST 14'h0001

// ------------------------------------------------------------
// Encodings
// ------------------------------------------------------------
`define IOGC_RATIO_X1 2'h0
`define IOGC_RATIO_X2 2'h1
`define IOGC_RATIO_X4 2'h2
`define IOGC_POS_A 2'h0
`define IOGC_POS_B 2'h1
`define IOGC_POS_C 2'h2
`define IOGC_POS_D 2'h3

// ------------------------------------------------------------
// Update chain and clock delay
// ------------------------------------------------------------
`define IOGC_CHAIN_W 4
`define IOGC_CHAIN_INIT 4'h1
`define IOGC_DLY_TAPS 4

`endif

// [hw/iogc_sync.v]
`timescale 1ns/1ns

// ------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ------------------------------------------------------------
module iogc_sync #(
    parameter RST_VAL = 1'b0
) (
    input wire sys_clk,
    input wire rst,
    input wire ce,
    input wire pinIn,
    output reg levelOut
);

    reg s1Q;
    reg s2Q;
    reg s3Q;

    // Stage one feeds only stage two; the level moves once two and three agree
    always @(posedge sys_clk) begin
        if (rst) begin
            s1Q <= RST_VAL;
            s2Q <= RST_VAL;
            s3Q <= RST_VAL;
            levelOut <= RST_VAL;
        end else if (ce) begin
            s1Q <= pinIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
            if (s2Q == s3Q) begin
                levelOut <= s3Q;
            end
        end
    end

endmodule // iogc_sync

// [hw/iogc_top.v]
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`include "iogc_defs.vh"

// Contract
// - Every passed control signal may be inverted; global set/reset never.
// - Global set/reset is passed through or fully blocked by config.
// - High-speed clock net comes from edge clock or routed clock.
// - Routed clock is the slow-speed clock of the gearing registers.
// - Selectable delays can be inserted into the high-speed input and output clock nets.
// - Generator makes rising and falling handoff strobes for gearing stages.
// - Strobes are active only in a gearing mode; idle otherwise.
// - Strobes time parallel handoff between fast and slow domains.
// - One strobe, chosen by config, is also driven out as update.
// - Generator is a shift chain on high-speed input or output clock.
// - Chain init loads a mode pattern fixing strobe period and phase; here 4'h1 in every mode, and rotation length sets the period.
// - Chain reset comes from edge or local reset per config.
// - Edge and local resets pass optional inversion before the generator.
// - Position limits ratios: A x1/2/4, C x1/2, B,D x1, tristate x1.
module iogc_top (
    input wire sys_clk,
    input wire rst,
    input wire ce,
    input wire [`IOGC_ADDR_W-1:0] regAddr,
    input wire [`IOGC_DATA_W-1:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [`IOGC_DATA_W-1:0] regRdData,
    input wire edgeClkIn,
    input wire routeClkIn,
    input wire [`IOGC_NCTRL-1:0] ctrlIn,
    input wire globalSetReset,
    output reg [`IOGC_NCTRL-1:0] ctrlOut,
    output reg gsrOut,
    output reg hsInClkOut,
    output reg hsOutClkOut,
    output reg slowClkOut,
    output reg edge_reset_to_updgen,
    output reg local_reset_to_updgen,
    output reg riseHandoffStrobe,
    output reg fall_handoff_strobe,
    output reg updateOut,
    output reg gearingActive
);

    // ------------------------------------------------------------
    // Registers and internal state
    // ------------------------------------------------------------
    reg [`IOGC_NCTRL-1:0] invMask_q;
    reg [`IOGC_CFG_W-1:0] cfg_q;
    reg [`IOGC_DLY_TAPS-1:0] hsDelay_q;
    reg chainClkPrev_q;
    reg [1:0] ratioSeen_q;
    reg [`IOGC_CHAIN_W-1:0] chain_q;
    reg [`IOGC_CHAIN_W-1:0] chain_d;
    reg [1:0] effRatio;
    reg ratioUnsupported;
    reg hsSelNet;
    reg hsInNet;
    reg hsOutNet;
    reg chainClkNet;
    reg chainReset;
    reg [`IOGC_DATA_W-1:0] rdMux;

    wire edgeClkSync;
    wire routeClkSync;
    wire [1:0] cfgRatio;
    wire [1:0] cfgPos;
    wire [1:0] cfgInDly;
    wire [1:0] cfgOutDly;
    wire chainRise;
    wire chainFall;

    assign cfgRatio = cfg_q[`IOGC_CFG_RATIO_HI:`IOGC_CFG_RATIO_LO];
    assign cfgPos = cfg_q[`IOGC_CFG_POS_HI:`IOGC_CFG_POS_LO];
    assign cfgInDly = cfg_q[`IOGC_CFG_INDLY_HI:`IOGC_CFG_INDLY_LO];
    assign cfgOutDly = cfg_q[`IOGC_CFG_OUTDLY_HI:`IOGC_CFG_OUTDLY_LO];

    // ------------------------------------------------------------
    // Clock pins arrive from outside the sys_clk domain
    // ------------------------------------------------------------
    iogc_sync #(
        .RST_VAL(1'b0)
    ) edgeSync (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .pinIn(edgeClkIn),
        .levelOut(edgeClkSync)
    );

    iogc_sync #(
        .RST_VAL(1'b0)
    ) routeSync (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .pinIn(routeClkIn),
        .levelOut(routeClkSync)
    );

    // ------------------------------------------------------------
    // Register bus slave
    // ------------------------------------------------------------

    // Writes land in one cycle; status is read only
    always @(posedge sys_clk) begin
        if (rst) begin
            invMask_q <= `IOGC_INV_RST;
            cfg_q <= `IOGC_CFG_RST;
        end else if (ce && regWr) begin
            if (regAddr == `IOGC_ADDR_INV) begin
                invMask_q <= regWrData[`IOGC_NCTRL-1:0];
            end
            if (regAddr == `IOGC_ADDR_CFG) begin
                cfg_q <= regWrData[`IOGC_CFG_W-1:0];
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always @* begin
        rdMux = 32'h0;
        case (regAddr)
            `IOGC_ADDR_INV: begin
                rdMux[`IOGC_NCTRL-1:0] = invMask_q;
            end
            `IOGC_ADDR_CFG: begin
                rdMux[`IOGC_CFG_W-1:0] = cfg_q;
            end
            `IOGC_ADDR_STAT: begin
                rdMux[3:0] = chain_q;
                rdMux[4] = gearingActive;
                rdMux[5] = ratioUnsupported;
                rdMux[6] = riseHandoffStrobe;
                rdMux[7] = fall_handoff_strobe;
                rdMux[9:8] = effRatio;
            end
            default: begin
                rdMux = 32'h0;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (rst) begin
            regRdData <= 32'h0;
        end else if (ce) begin
            regRdData <= regRd ? rdMux : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Control stage
    // ------------------------------------------------------------

    // Per-lane inversion; edge and local reset lanes also feed the generator
    always @(posedge sys_clk) begin
        if (rst) begin
            ctrlOut <= 4'h0;
            gsrOut <= 1'b0;
            edge_reset_to_updgen <= 1'b0;
            local_reset_to_updgen <= 1'b0;
        end else if (ce) begin
            ctrlOut <= ctrlIn ^ invMask_q;
            // No inversion path exists for the global set/reset
            gsrOut <= globalSetReset & cfg_q[`IOGC_CFG_GSREN];
            edge_reset_to_updgen <= ctrlIn[`IOGC_CTL_EDGE] ^
                invMask_q[`IOGC_CTL_EDGE];
            local_reset_to_updgen <= ctrlIn[`IOGC_CTL_LOCAL] ^
                invMask_q[`IOGC_CTL_LOCAL];
        end
    end

    // High-speed source select ahead of the delay line
    always @* begin
        hsSelNet = cfg_q[`IOGC_CFG_HSSEL] ? routeClkSync : edgeClkSync;
    end

    // Delay line; each tap adds one sys_clk period to the clock net
    always @(posedge sys_clk) begin
        if (rst) begin
            hsDelay_q <= 4'h0;
        end else if (ce) begin
            hsDelay_q <= {hsDelay_q[`IOGC_DLY_TAPS-2:0], hsSelNet};
        end
    end

    // Input and output nets take their own tap, so they can skew apart
    always @* begin
        hsInNet = hsDelay_q[cfgInDly];
        hsOutNet = hsDelay_q[cfgOutDly];
        chainClkNet = cfg_q[`IOGC_CFG_CHAINSEL] ? hsOutNet : hsInNet;
    end

    // Clock nets driven out to the cell
    always @(posedge sys_clk) begin
        if (rst) begin
            hsInClkOut <= 1'b0;
            hsOutClkOut <= 1'b0;
            slowClkOut <= 1'b0;
        end else if (ce) begin
            hsInClkOut <= hsInNet;
            hsOutClkOut <= hsOutNet;
            slowClkOut <= routeClkSync;
        end
    end

    // ------------------------------------------------------------
    // Gearing capability by cell position
    // ------------------------------------------------------------

    // An unsupported ratio falls back to x1 so the pin still works
    always @* begin
        ratioUnsupported = 1'b0;
        case (cfgPos)
            `IOGC_POS_A: begin
                ratioUnsupported = (cfgRatio != `IOGC_RATIO_X1) &&
                    (cfgRatio != `IOGC_RATIO_X2) &&
                    (cfgRatio != `IOGC_RATIO_X4);
            end
            `IOGC_POS_C: begin
                ratioUnsupported = (cfgRatio != `IOGC_RATIO_X1) &&
                    (cfgRatio != `IOGC_RATIO_X2);
            end
            default: begin
                ratioUnsupported = cfgRatio != `IOGC_RATIO_X1;
            end
        endcase
        if (cfg_q[`IOGC_CFG_TRIST] && cfgRatio != `IOGC_RATIO_X1) begin
            ratioUnsupported = 1'b1;
        end
        effRatio = ratioUnsupported ? `IOGC_RATIO_X1 : cfgRatio;
    end

    // ------------------------------------------------------------
    // Update generator
    // ------------------------------------------------------------
    assign chainRise = chainClkNet & ~chainClkPrev_q;
    assign chainFall = ~chainClkNet & chainClkPrev_q;

    // Reset source select after the control stage inversion
    always @* begin
        chainReset = cfg_q[`IOGC_CFG_RSTSEL] ?
            local_reset_to_updgen : edge_reset_to_updgen;
    end

    // Rotation length equals the ratio, so one bit in N is set
    always @* begin
        chain_d = chain_q;
        case (effRatio)
            `IOGC_RATIO_X2: begin
                chain_d = {2'b00, chain_q[0], chain_q[1]};
            end
            `IOGC_RATIO_X4: begin
                chain_d = {chain_q[0], chain_q[3:1]};
            end
            default: begin
                chain_d = chain_q;
            end
        endcase
    end

    // Chain edge tracker and shift; reset wins over a clock edge
    always @(posedge sys_clk) begin
        if (rst) begin
            chainClkPrev_q <= 1'b0;
            ratioSeen_q <= `IOGC_RATIO_X1;
            chain_q <= `IOGC_CHAIN_INIT;
        end else if (ce) begin
            chainClkPrev_q <= chainClkNet;
            ratioSeen_q <= effRatio;
            // Any ratio change reloads, or a stale x4 bit could stall x2
            if (chainReset || ratioSeen_q != effRatio) begin
                chain_q <= `IOGC_CHAIN_INIT;
            end else if (chainRise) begin
                chain_q <= chain_d;
            end
        end
    end

    // Strobes: rising strobe follows the rising edge, falling one the fall
    always @(posedge sys_clk) begin
        if (rst) begin
            gearingActive <= 1'b0;
            riseHandoffStrobe <= 1'b0;
            fall_handoff_strobe <= 1'b0;
            updateOut <= 1'b0;
        end else if (ce) begin
            gearingActive <= effRatio != `IOGC_RATIO_X1;
            if (!gearingActive || chainReset) begin
                // Outside gearing modes the strobes stay quiet
                riseHandoffStrobe <= 1'b0;
                fall_handoff_strobe <= 1'b0;
                updateOut <= 1'b0;
            end else begin
                if (chainRise) begin
                    riseHandoffStrobe <= chain_d[0];
                    if (!cfg_q[`IOGC_CFG_UPDSEL]) begin
                        updateOut <= chain_d[0];
                    end
                end
                if (chainFall) begin
                    fall_handoff_strobe <= chain_q[0];
                    if (cfg_q[`IOGC_CFG_UPDSEL]) begin
                        updateOut <= chain_q[0];
                    end
                end
            end
        end
    end

endmodule // iogc_top

// [testbench/iogc_props.sv]
`timescale 1ns/1ns
`include "iogc_defs.vh"
// ------------------------------
// Checker on the top-level ports
// ------------------------------
module iogc_props (
    input wire sys_clk,
    input wire rst,
    input wire ce,
    input wire regRd,
    input wire [`IOGC_DATA_W-1:0] regRdData,
    input wire edgeClkIn,
    input wire routeClkIn,
    input wire [`IOGC_NCTRL-1:0] ctrlOut,
    input wire globalSetReset,
    input wire gsrOut,
    input wire hsInClkOut,
    input wire slowClkOut,
    input wire edge_reset_to_updgen,
    input wire local_reset_to_updgen,
    input wire riseHandoffStrobe,
    input wire fall_handoff_strobe,
    input wire updateOut,
    input wire gearingActive
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    reg [3:0] calm_q;
    // Pins still for 15 cycles: sync plus taps must have settled by then
    always @(posedge sys_clk) begin
        if (rst || !ce || $changed({edgeClkIn, routeClkIn}))
            calm_q <= 4'h0;
        else if (calm_q != 4'hf)
            calm_q <= calm_q + 4'h1;
    end
    AST_GSR_GATE: assert property ($past(ce) && gsrOut
        |-> $past(globalSetReset)) else $error("gsr not gated");
    AST_EDGE_RST: assert property (edge_reset_to_updgen
        == ctrlOut[`IOGC_CTL_EDGE]) else $error("edge reset path");
    AST_LOCAL_RST: assert property (local_reset_to_updgen
        == ctrlOut[`IOGC_CTL_LOCAL]) else $error("local reset path");
    AST_IDLE: assert property (!gearingActive [*3] |->
        !riseHandoffStrobe && !fall_handoff_strobe && !updateOut)
        else $error("strobe outside gearing");
    AST_UPD_SRC: assert property (updateOut |-> riseHandoffStrobe
        || fall_handoff_strobe || $past(riseHandoffStrobe)
        || $past(fall_handoff_strobe)) else $error("update unsourced");
    AST_RST_CLR: assert property (disable iff (1'b0)
        rst && ce |=> ctrlOut == 4'h0 && !gsrOut && !updateOut
        && !riseHandoffStrobe && !fall_handoff_strobe)
        else $error("outputs live in reset");
    AST_RD_IDLE: assert property ($past(ce) && !$past(regRd)
        |-> regRdData == 32'h0) else $error("read data unasked");
    AST_SLOW_CLK: assert property (calm_q == 4'hf
        |-> slowClkOut == routeClkIn) else $error("slow clock wrong");
    AST_HS_SRC: assert property (calm_q == 4'hf |->
        hsInClkOut == edgeClkIn || hsInClkOut == routeClkIn)
        else $error("fast clock unsourced");
    COV_RISE: cover property (gearingActive && $rose(riseHandoffStrobe));
    COV_FALL: cover property (gearingActive && $rose(fall_handoff_strobe));
    COV_UPD: cover property ($rose(updateOut));
endmodule // iogc_props

bind iogc_top iogc_props iogc_props_i (.sys_clk, .rst, .ce, .regRd,
    .regRdData, .edgeClkIn, .routeClkIn, .ctrlOut, .globalSetReset,
    .gsrOut, .hsInClkOut, .slowClkOut, .edge_reset_to_updgen,
    .local_reset_to_updgen, .riseHandoffStrobe, .fall_handoff_strobe,
    .updateOut, .gearingActive);

// [testbench/iogc_gear_model.sv]
`timescale 1ns/1ns
// ------------------------------------------
// Gearing register stand-in: counts handoffs
// ------------------------------------------
module iogc_gear_model (
    input wire sys_clk,
    input wire clear,
    input wire fastClk,
    input wire handoff,
    output reg [7:0] clkCnt_q,
    output reg [7:0] hoCnt_q
);
    reg fast_q;
    reg hand_q;
    // One slow word moves per handoff rise; count rising edges of both inputs
    always @(posedge sys_clk) begin
        fast_q <= fastClk;
        hand_q <= handoff;
        if (clear) begin
            clkCnt_q <= 8'h0;
            hoCnt_q <= 8'h0;
        end else begin
            if (fastClk && !fast_q)
                clkCnt_q <= clkCnt_q + 8'h1;
            if (handoff && !hand_q)
                hoCnt_q <= hoCnt_q + 8'h1;
        end
    end
endmodule // iogc_gear_model

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`include "iogc_defs.vh"
// ---------------------------
// Bench for the gearing block
// ---------------------------
module tb_top;
    reg sys_clk = 1'h0, rst = 1'h1, ce = 1'h1, regWr = 1'h0, regRd = 1'h0;
    reg edgeClkIn = 1'h0, routeClkIn = 1'h0, globalSetReset = 1'h0;
    reg clear = 1'h1, run = 1'h1;
    reg [7:0] regAddr = 8'h0;
    reg [31:0] regWrData = 32'h0, v;
    reg [3:0] ctrlIn = 4'h0;
    wire [31:0] regRdData;
    wire [3:0] ctrlOut;
    wire gsrOut, hsInClkOut, hsOutClkOut, slowClkOut, gearingActive;
    wire edge_reset_to_updgen, local_reset_to_updgen, updateOut;
    wire riseHandoffStrobe, fall_handoff_strobe;
    wire [7:0] clkCnt, riseCnt, updCnt, outCnt;
    integer fail_count = 0, samples_checked = 0, tick = 0, i;
    // Cases: cfg, control lanes, expected active, strobe ratio
    localparam [195:0] CFGS = {14'h0401, 14'h0201, 14'h1201, 14'h1401,
        14'h0a01, 14'h1a01, 14'h2401, 14'h0001, 14'h0601, 14'h04cf,
        14'h0281, 14'h0501, 14'h0501, 14'h0401};
    localparam [55:0] CTLS = 56'h00000000000244;
    localparam [55:0] NS = 56'h42200000042040;
    localparam [13:0] ACTS = 14'h381f;

    always #5 sys_clk = ~sys_clk;
    // Slow pin clocks so the synchronisers can follow them
    always @(posedge sys_clk) begin
        tick <= tick + 1;
        if (run && tick % 5 == 0) edgeClkIn <= ~edgeClkIn;
        if (run && tick % 8 == 0) routeClkIn <= ~routeClkIn;
    end

    iogc_top iogc_top_i (.sys_clk, .rst, .ce, .regAddr, .regWrData, .regWr,
        .regRd, .regRdData, .edgeClkIn, .routeClkIn, .ctrlIn,
        .globalSetReset, .ctrlOut, .gsrOut, .hsInClkOut, .hsOutClkOut,
        .slowClkOut, .edge_reset_to_updgen, .local_reset_to_updgen,
        .riseHandoffStrobe, .fall_handoff_strobe, .updateOut, .gearingActive);
    iogc_gear_model gearRise_i (.sys_clk, .clear, .fastClk(hsInClkOut),
        .handoff(riseHandoffStrobe), .clkCnt_q(clkCnt), .hoCnt_q(riseCnt));
    iogc_gear_model gearUpd_i (.sys_clk, .clear, .fastClk(hsOutClkOut),
        .handoff(updateOut), .clkCnt_q(outCnt), .hoCnt_q(updCnt));

    task chk(input [31:0] seen, input [31:0] exp, input [63:0] name);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch %0s exp %h seen %h", name, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            regAddr <= a;
            regWrData <= d;
            regWr <= 1'h1;
            @(posedge sys_clk);
            regWr <= 1'h0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge sys_clk);
            regAddr <= a;
            regRd <= 1'h1;
            @(posedge sys_clk);
            regRd <= 1'h0;
            @(negedge sys_clk);
            v = regRdData;
        end
    endtask
    // Run one mode long enough to see tens of fast clock rises
    task gear(input [13:0] cfg, input [3:0] ctl, input act, input [3:0] n);
        integer c, e, r, u;
        begin
            @(posedge sys_clk);
            ctrlIn <= ctl;
            wr(`IOGC_ADDR_CFG, {18'h0, cfg});
            repeat (40) @(posedge sys_clk);
            clear <= 1'h1;
            @(posedge sys_clk);
            clear <= 1'h0;
            repeat (800) @(posedge sys_clk);
            @(negedge sys_clk);
            c = clkCnt;
            e = cfg[`IOGC_CFG_HSSEL] ? 50 : 80;
            chk(gearingActive, act, "active");
            chk(c >= e - 1 && c <= e + 1, 1, "clkrise");
            chk(outCnt + 1 >= e && outCnt <= e + 1, 1, "outrise");
            // A zero ratio means the strobes must stay silent
            r = riseCnt * n;
            u = updCnt * n;
            chk(n ? r + n >= c && r <= c + n : !riseCnt, 1, "rise");
            chk(n ? u + n >= c && u <= c + n : !updCnt, 1, "update");
            rd(`IOGC_ADDR_STAT);
            chk(v[9:8], act ? cfg[10:9] : 2'h0, "effratio");
            chk(v[5], !act && cfg[10:9] != 2'h0, "unsupp");
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    // Watchdog well beyond the ~12000 cycles of the sequence
    initial begin
        repeat (30000) @(posedge sys_clk);
        fail_count = fail_count + 1;
        summarize;
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'h0;
        rd(`IOGC_ADDR_INV);
        chk(v, 32'h0, "inv");
        rd(`IOGC_ADDR_CFG);
        chk(v, 32'h1, "cfg");
        rd(8'h0c);
        chk(v, 32'h0, "unmapped");
        wr(`IOGC_ADDR_INV, 32'hffffffff);
        rd(`IOGC_ADDR_INV);
        chk(v, 32'hf, "inv");
        @(posedge sys_clk);
        ce <= 1'h0;
        wr(`IOGC_ADDR_INV, 32'h3);
        ce <= 1'h1;
        rd(`IOGC_ADDR_INV);
        chk(v, 32'hf, "cehold");
        @(posedge sys_clk);
        ctrlIn <= 4'h5;
        globalSetReset <= 1'h1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(ctrlOut, 4'ha, "ctrlOut");
        chk(edge_reset_to_updgen, 1'h0, "edgeRst");
        chk(local_reset_to_updgen, 1'h1, "localRst");
        chk(gsrOut, 1'h1, "gsr");
        wr(`IOGC_ADDR_CFG, 32'h0);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(gsrOut, 1'h0, "gsr");
        wr(`IOGC_ADDR_INV, 32'h0);
        for (i = 13; i >= 0; i = i - 1)
            gear(CFGS[i*14+:14], CTLS[i*4+:4], ACTS[i], NS[i*4+:4]);
        @(posedge sys_clk);
        run <= 1'h0;
        repeat (40) @(posedge sys_clk);
        summarize;
    end
endmodule // tb_top
